// ==== core/smbfu_core.sv ====
// SMBus controller flag update logic with bit engine and receive buffer.
`timescale 1ns/1ps
`default_nettype none
`include "smbfu_cfg.svh"

module smbfu_buf (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    import smbfu_pkg::*;

    smbfu_entry_t head;
    smbfu_entry_t tail;
    smbfu_entry_t next_head;
    smbfu_entry_t next_tail;

    always_comb begin
        next_head = head;
        next_tail = tail;
        if (head.valid && out_ready) begin
            next_head = tail;
            next_tail.valid = 1'b0;
        end
        if (in_valid && !tail.valid) begin
            if (!next_head.valid) begin
                next_head = {1'b1, in_data};
            end else begin
                next_tail = {1'b1, in_data};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            head <= {1'b0, `SMBFU_BYTE_RST};
            tail <= {1'b0, `SMBFU_BYTE_RST};
        end else if (ce) begin
            head <= next_head;
            tail <= next_tail;
        end
    end

    assign in_ready = !tail.valid;
    assign out_valid = head.valid;
    assign out_data = head.data;
endmodule

module smbfu_core (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [6:0] own_addr,
    input wire logic data_wr,
    input wire logic [7:0] data_in,
    input wire logic sta_set,
    input wire logic sta_clear,
    input wire logic sto_set,
    input wire logic si_clear,
    input wire logic ack_resp,
    output smbfu_pkg::smbfu_flags_t flags,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready
);
    import smbfu_pkg::*;

    logic scl_q1, scl_s, scl_p;
    logic sda_q1, sda_s, sda_p;
    logic scl_rise, scl_fall, start_det, stop_det;
    smbfu_flags_t next_flags;
    smbfu_state_t state, next_state;
    logic [11:0] tmr, next_tmr;
    logic [3:0] cnt, next_cnt;
    logic [7:0] rxsh, next_rxsh;
    logic [7:0] dreg, next_dreg;
    logic dwr, next_dwr;
    logic busy, next_busy;
    logic addr_ph, next_addr_ph;
    logic addressed, next_addressed;
    logic going_stop, next_going_stop;
    logic next_scl_oe, next_sda_oe;
    logic push, arb, si_set, hold, tx_bit, buf_ready, engaged;

    // Pin synchronisers; only the second stage and later are looked at.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q1 <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_q1 <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
        end else if (ce) begin
            scl_q1 <= scl_in;
            scl_s <= scl_q1;
            scl_p <= scl_s;
            sda_q1 <= sda_in;
            sda_s <= sda_q1;
            sda_p <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_det = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det = scl_s && scl_p && !sda_p && sda_s;
    assign tx_bit = dreg[~cnt[2:0]];
    assign engaged = flags.master || addressed;
    // A full buffer or a pending interrupt stretches SCL low.
    assign hold = flags.interrupt || !buf_ready;

    always_comb begin
        next_flags = flags;
        next_state = state;
        next_tmr = (tmr == 12'h000) ? tmr : tmr - 12'h001;
        next_cnt = cnt;
        next_rxsh = rxsh;
        next_dreg = dreg;
        next_dwr = dwr;
        next_busy = busy;
        next_addr_ph = addr_ph;
        next_addressed = addressed;
        next_going_stop = going_stop;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        push = 1'b0;
        arb = 1'b0;
        si_set = 1'b0;

        if (data_wr) begin
            next_dreg = data_in;
            next_dwr = 1'b1;
        end
        if (sta_set) begin
            next_flags.start_flag = 1'b1;
        end
        if (sta_clear) begin
            next_flags.start_flag = 1'b0;
        end
        if (sto_set) begin
            next_flags.stop_flag = 1'b1;
        end
        if (si_clear) begin
            next_flags.interrupt = 1'b0;
            next_flags.arbitration_lost_flag = 1'b0;
        end

        if (start_det) begin
            next_busy = 1'b1;
            next_cnt = 4'h0;
            next_addr_ph = 1'b1;
            next_addressed = 1'b0;
            if (state != SMBFU_START) begin
                if (flags.master && !flags.start_flag) begin
                    arb = 1'b1;
                end
                next_flags.transmit_direction_flag = dwr;
                next_dwr = 1'b0;
            end
        end

        if (stop_det) begin
            next_busy = 1'b0;
            next_addressed = 1'b0;
            next_addr_ph = 1'b0;
            if (addressed) begin
                next_flags.stop_flag = 1'b1;
                si_set = 1'b1;
            end
            if (state == SMBFU_STOP) begin
                next_flags.stop_flag = 1'b0;
                next_flags.master = 1'b0;
                next_state = SMBFU_IDLE;
            end else if (flags.master) begin
                next_flags.stop_flag = 1'b1;
                arb = 1'b1;
            end
        end

        if (busy && (state == SMBFU_XFER || state == SMBFU_IDLE)) begin
            if (scl_rise && cnt != `SMBFU_ACK_BIT) begin
                next_rxsh = {rxsh[6:0], sda_s};
                next_cnt = cnt + 4'h1;
                if (flags.master && flags.transmit_direction_flag && tx_bit && !sda_s) begin
                    arb = 1'b1;
                end
                if (cnt == `SMBFU_LAST_BIT) begin
                    next_addr_ph = 1'b0;
                    if (addr_ph && !flags.master && rxsh[6:0] == own_addr) begin
                        next_addressed = 1'b1;
                        next_flags.start_flag = 1'b1;
                        next_flags.transmit_direction_flag = sda_s;
                        next_flags.ack_request_flag = 1'b1;
                        si_set = 1'b1;
                    end else if (engaged && !flags.transmit_direction_flag) begin
                        push = 1'b1;
                        next_flags.ack_request_flag = 1'b1;
                        si_set = 1'b1;
                    end
                end
            end else if (scl_rise) begin
                next_cnt = 4'h0;
                if (engaged && flags.transmit_direction_flag) begin
                    next_flags.ack = !sda_s;
                    next_dwr = 1'b0;
                    si_set = 1'b1;
                end
            end
            if (scl_fall && cnt == 4'h0) begin
                next_flags.ack_request_flag = 1'b0;
            end
            if (!scl_s) begin
                if (cnt == `SMBFU_ACK_BIT) begin
                    next_sda_oe = engaged && !flags.transmit_direction_flag && ack_resp;
                end else begin
                    next_sda_oe = engaged && flags.transmit_direction_flag && !tx_bit;
                end
            end
        end

        case (state)
            SMBFU_IDLE: begin
                next_scl_oe = addressed && hold && (!scl_s || scl_oe);
                if (flags.start_flag && !busy && !flags.master) begin
                    next_state = SMBFU_START;
                    next_sda_oe = 1'b1;
                    next_tmr = `SMBFU_HALF_CYC;
                end
            end
            SMBFU_START: begin
                if (tmr == 12'h000) begin
                    next_flags.master = 1'b1;
                    next_flags.transmit_direction_flag = 1'b1;
                    si_set = 1'b1;
                    next_scl_oe = 1'b1;
                    next_tmr = `SMBFU_HALF_CYC;
                    next_state = SMBFU_XFER;
                end
            end
            SMBFU_XFER: begin
                if (si_clear && cnt == 4'h0 &&
                    (flags.stop_flag || (flags.start_flag && !sta_clear))) begin
                    next_state = SMBFU_EDGE;
                    next_going_stop = flags.stop_flag;
                    next_sda_oe = flags.stop_flag;
                    next_tmr = `SMBFU_HALF_CYC;
                end else if (tmr == 12'h000) begin
                    if (scl_oe && !hold) begin
                        next_scl_oe = 1'b0;
                        next_tmr = `SMBFU_HALF_CYC;
                    end else if (!scl_oe && scl_s) begin
                        next_scl_oe = 1'b1;
                        next_tmr = `SMBFU_HALF_CYC;
                    end
                end
            end
            SMBFU_EDGE: begin
                if (tmr == 12'h000) begin
                    if (scl_oe) begin
                        next_scl_oe = 1'b0;
                        next_tmr = `SMBFU_HALF_CYC;
                    end else if (!scl_s) begin
                        arb = 1'b1;
                    end else if (going_stop) begin
                        next_sda_oe = 1'b0;
                        next_state = SMBFU_STOP;
                    end else begin
                        next_sda_oe = 1'b1;
                        next_tmr = `SMBFU_HALF_CYC;
                        next_state = SMBFU_START;
                    end
                end
            end
            SMBFU_STOP: begin
                next_sda_oe = 1'b0;
            end
            default: begin
                next_state = SMBFU_IDLE;
            end
        endcase

        if (arb) begin
            next_flags.arbitration_lost_flag = 1'b1;
            next_flags.master = 1'b0;
            next_flags.transmit_direction_flag = 1'b0;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_state = SMBFU_IDLE;
            si_set = 1'b1;
        end
        if (si_set) begin
            next_flags.interrupt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= `SMBFU_FLAGS_RST;
            state <= SMBFU_IDLE;
            tmr <= 12'h000;
            cnt <= 4'h0;
            rxsh <= `SMBFU_BYTE_RST;
            dreg <= `SMBFU_BYTE_RST;
            dwr <= 1'b0;
            busy <= 1'b0;
            addr_ph <= 1'b0;
            addressed <= 1'b0;
            going_stop <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            flags <= next_flags;
            state <= next_state;
            tmr <= next_tmr;
            cnt <= next_cnt;
            rxsh <= next_rxsh;
            dreg <= next_dreg;
            dwr <= next_dwr;
            busy <= next_busy;
            addr_ph <= next_addr_ph;
            addressed <= next_addressed;
            going_stop <= next_going_stop;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    smbfu_buf u_rx_buf (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .in_valid(push),
        .in_data({rxsh[6:0], sda_s}),
        .in_ready(buf_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );
endmodule

`default_nettype wire

// ==== core/smbfu_cfg.svh ====
// Timing counts, bit positions and reset values of the SMBus flag logic.
`ifndef SMBFU_CFG_SVH
`define SMBFU_CFG_SVH
`define SMBFU_CLK_NS 10
`define SMBFU_HALF_NS 5000
`define SMBFU_HALF_CYC 12'((`SMBFU_HALF_NS + `SMBFU_CLK_NS - 1) / `SMBFU_CLK_NS)
`define SMBFU_LAST_BIT 4'h7
`define SMBFU_ACK_BIT 4'h8
`define SMBFU_FLAGS_RST 8'h00
`define SMBFU_BYTE_RST 8'h00
`endif

// ==== core/smbfu_pkg.sv ====
// Types shared by the SMBus flag update logic.
`default_nettype none
package smbfu_pkg;
    typedef struct packed {
        logic master;
        logic transmit_direction_flag;
        logic start_flag;
        logic stop_flag;
        logic ack_request_flag;
        logic arbitration_lost_flag;
        logic ack;
        logic interrupt;
    } smbfu_flags_t;

    typedef enum logic [2:0] {
        SMBFU_IDLE = 3'b000,
        SMBFU_START = 3'b001,
        SMBFU_XFER = 3'b010,
        SMBFU_EDGE = 3'b011,
        SMBFU_STOP = 3'b100
    } smbfu_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } smbfu_entry_t;
endpackage
`default_nettype wire

// ==== verif/smbfu_core_chk.sv ====
// Concurrent checks on the ports of the SMBus flag update logic.
`timescale 1ns/1ps
`default_nettype none
module smbfu_core_chk (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic sta_set,
    input wire logic sta_clear,
    input wire logic sto_set,
    input wire logic si_clear,
    input wire smbfu_pkg::smbfu_flags_t flags,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready
);
    import smbfu_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_start_keep: assert property (flags.start_flag && !sta_clear |=> flags.start_flag)
        else $error("start flag dropped by hardware");
    a_start_req: assert property (sta_set && !sta_clear |=> flags.start_flag)
        else $error("start request not held");
    a_int_keep: assert property (flags.interrupt && !si_clear |=> flags.interrupt)
        else $error("interrupt dropped by hardware");
    a_arb_side: assert property ($rose(flags.arbitration_lost_flag) |->
        flags.interrupt && !flags.master && !flags.transmit_direction_flag)
        else $error("arbitration loss side effects missing");
    a_master_rise: assert property ($rose(flags.master) |->
        flags.transmit_direction_flag && flags.interrupt)
        else $error("master entry without direction or interrupt");
    a_ack_request_flag_int: assert property ($rose(flags.ack_request_flag) |-> flags.interrupt)
        else $error("received byte without interrupt");
    a_stop_int: assert property ($rose(flags.stop_flag) && !$past(sto_set) |->
        flags.interrupt)
        else $error("stop seen without interrupt");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte lost or changed");
endmodule
bind smbfu_core smbfu_core_chk i_smbfu_core_chk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sta_set(sta_set),
    .sta_clear(sta_clear),
    .sto_set(sto_set),
    .si_clear(si_clear),
    .flags(flags),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready)
);
`default_nettype wire

// ==== verif/smbfu_peer.sv ====
// Behavioural second bus master and acknowledging slave on the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module smbfu_peer (
    input wire logic ref_clk,
    input wire logic scl_w,
    input wire logic sda_w,
    output var logic scl_low,
    output var logic sda_low
);
    logic last_ack = 1'b1;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // A bus half period of 40 ns.
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask
    // Releases the clock and waits while the device stretches it.
    task automatic hi();
        scl_low <= 1'b0;
        while (!scl_w) @(posedge ref_clk);
        half();
    endtask
    task automatic start();
        @(posedge ref_clk);
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b1;
        half();
    endtask
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_low <= !b[i];
            half();
            hi();
            scl_low <= 1'b1;
        end
        sda_low <= 1'b0;
        half();
        hi();
        last_ack = sda_w;
        scl_low <= 1'b1;
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        half();
        hi();
        sda_low <= 1'b0;
        half();
    endtask
    task automatic hold(input logic v);
        @(posedge ref_clk);
        sda_low <= v;
    endtask
    // Acts as an addressed slave: lets eight bits pass, then pulls SDA low for the ninth.
    task automatic ack_byte();
        repeat (8) @(posedge scl_w);
        @(negedge scl_w);
        @(posedge ref_clk);
        sda_low <= 1'b1;
        @(negedge scl_w);
        @(posedge ref_clk);
        sda_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_smbfu_core.sv ====
// Self-checking bench for the SMBus flag update logic.
`timescale 1ns/1ps
`default_nettype none
module test_smbfu_core;
    import smbfu_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic data_wr = 1'b0;
    logic sta_set = 1'b0;
    logic sta_clear = 1'b0;
    logic sto_set = 1'b0;
    logic si_clear = 1'b0;
    logic rx_ready = 1'b0;
    logic [7:0] data_in = 8'h00;
    logic scl_oe, sda_oe, rx_valid, p_scl, p_sda, scl_out, sda_out;
    logic [7:0] rx_data;
    smbfu_flags_t flags;
    wire logic scl_w = !(scl_oe | p_scl);
    wire logic sda_w = !(sda_oe | p_sda);
    int error_cnt = 0;
    int num_checks = 0;
    smbfu_core i_smbfu_core (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .own_addr(ADDR), .data_wr(data_wr), .data_in(data_in), .sta_set(sta_set),
        .sta_clear(sta_clear), .sto_set(sto_set), .si_clear(si_clear), .ack_resp(1'b1),
        .flags(flags), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
    smbfu_peer i_smbfu_peer (.ref_clk(ref_clk), .scl_w(scl_w), .sda_w(sda_w),
        .scl_low(p_scl), .sda_low(p_sda));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pulse order: sta_set, sta_clear, sto_set, si_clear, data_wr.
    task automatic sw(input logic [4:0] m);
        @(posedge ref_clk);
        {sta_set, sta_clear, sto_set, si_clear, data_wr} <= m;
        @(posedge ref_clk);
        {sta_set, sta_clear, sto_set, si_clear, data_wr} <= 5'h00;
    endtask
    task automatic wait_int();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (flags.interrupt !== 1'b1 && n < 12000) begin
            @(negedge ref_clk);
            n++;
        end
        if (flags.interrupt !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t interrupt wait timed out", $time);
        end
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check(flags, 8'h00);
        check({4'h0, scl_out, sda_out, scl_oe | sda_oe, rx_valid}, 8'h00);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic sbyte(input logic [7:0] b, input logic [7:0] exp);
        fork
            i_smbfu_peer.put_byte(b);
            begin
                wait_int();
                check(flags & 8'hFD, exp);
                sw(5'b00010);
            end
        join
        check({7'h00, i_smbfu_peer.last_ack}, 8'h00);
    endtask
    task automatic pop(input logic [7:0] exp);
        @(negedge ref_clk);
        check({7'h00, rx_valid}, 8'h01);
        check(rx_data, exp);
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
    endtask
    initial begin
        #500000;
        error_cnt++;
        final_report();
    end
    initial begin
        do_reset();
        sw(5'b10000);
        wait_int();
        check(flags & 8'hFD, 8'hE1);
        @(posedge ref_clk);
        data_in <= 8'h54;
        sw(5'b00001);
        fork
            i_smbfu_peer.ack_byte();
            begin
                sw(5'b01010);
                wait_int();
                check(flags, 8'hC3);
                repeat (600) @(negedge ref_clk);
                check({6'h00, scl_oe, flags.interrupt}, 8'h03);
                sw(5'b00100);
                sw(5'b00010);
            end
        join
        repeat (1100) @(negedge ref_clk);
        check(flags & 8'hBD, 8'h00);
        sw(5'b10000);
        wait_int();
        check(flags & 8'hFD, 8'hE1);
        i_smbfu_peer.hold(1'b1);
        @(posedge ref_clk);
        data_in <= 8'hFF;
        sw(5'b00001);
        sw(5'b01010);
        wait_int();
        check(flags & 8'hFD, 8'h05);
        sw(5'b00010);
        @(negedge ref_clk);
        check(flags & 8'hFD, 8'h00);
        i_smbfu_peer.hold(1'b0);
        do_reset();
        i_smbfu_peer.start();
        sbyte({ADDR, 1'b0}, 8'h29);
        sbyte(8'hA5, 8'h29);
        fork
            sbyte(8'h3C, 8'h29);
            begin
                repeat (300) @(negedge ref_clk);
                check({6'h00, scl_oe, flags.interrupt}, 8'h02);
                pop(8'hA5);
                pop(8'h3C);
            end
        join
        sbyte(8'h96, 8'h29);
        pop(8'h96);
        i_smbfu_peer.stop();
        wait_int();
        check(flags & 8'hFD, 8'h31);
        final_report();
    end
endmodule
`default_nettype wire
